// ### rtl/fes_sequencer.v
// Instruction fetch and execute sequencer with program counter and AXI4-Lite registers.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fes_regs.vh"
module fes_sequencer
#(
    parameter PCW = `FES_PC_W,
    parameter IW = `FES_INSTR_W,
    parameter DEPTH = `FES_STACK_DEPTH,
    parameter PW = `FES_STACK_PW
)
(
    input wire aclk,
    input wire aresetn,
    input wire [`FES_AXI_AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`FES_AXI_AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [PCW-1:0] pm_addr,
    output wire pm_rd,
    input wire [IW-1:0] pm_data,
    output wire [3:0] instruction_phase_clocks,
    output reg [IW-1:0] instr_word,
    output reg instr_valid,
    input wire ctl_jump,
    input wire ctl_call,
    input wire ctl_ret,
    input wire ctl_skip,
    input wire [PCW-1:0] ctl_target,
    input wire irq_req,
    input wire [PCW-1:0] irq_vector,
    output reg irq_ack
);
    localparam [PCW-1:0] PC_ONE = 1;
    localparam [PCW-1:0] RESET_PC = `FES_RESET_VECTOR;

    wire run;
    wire fetch_end;
    wire cycle_end;
    wire [3:0] phase;
    wire [PCW-1:0] stack_top;
    wire stack_full;
    wire [PW:0] stack_level;

    reg ctrl_run;
    reg pcl_pend;
    reg [`FES_PCL_W-1:0] pcl_val;
    reg [IW-1:0] fetch_q;
    reg [PCW-1:0] next_pc;
    reg next_discard;
    reg do_push;
    reg do_pop;
    reg take_irq;
    reg take_pcl;

    reg aw_held;
    reg [`FES_AXI_AW-1:0] aw_addr_q;
    reg w_held;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire wr_commit;
    wire pcl_write;
    reg [31:0] rd_mux;
    reg rd_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase generation and the program memory fetch strobe.
    assign run = ctrl_run;

    fes_phase_gen u_phase
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .phase(phase),
        .fetch_end(fetch_end),
        .cycle_end(cycle_end)
    );

    assign instruction_phase_clocks = phase;
    assign pm_rd = run & phase[0];

    fes_ret_stack
    #(
        .W(PCW),
        .DEPTH(DEPTH),
        .PW(PW)
    )
    u_stack
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(do_push),
        .pop(do_pop),
        .push_data(pm_addr),
        .top_data(stack_top),
        .full(stack_full),
        .level(stack_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next counter value chosen at the end of phase four.
    always @*
    begin
        next_pc = pm_addr + PC_ONE;
        next_discard = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        take_irq = 1'b0;
        take_pcl = 1'b0;
        if (cycle_end)
        begin
            if (instr_valid && (ctl_jump || ctl_call))
            begin
                next_pc = ctl_target;
                next_discard = 1'b1;
                do_push = ctl_call;
            end
            else if (instr_valid && ctl_ret)
            begin
                next_pc = stack_top;
                next_discard = 1'b1;
                do_pop = 1'b1;
            end
            else if (instr_valid && ctl_skip)
            begin
                next_discard = 1'b1;
            end
            else if (pcl_pend)
            begin
                next_pc = {pm_addr[PCW-1:`FES_PCL_W], pcl_val};
                next_discard = 1'b1;
                take_pcl = 1'b1;
            end
            else if (irq_req && !stack_full)
            begin
                next_pc = irq_vector;
                next_discard = 1'b1;
                do_push = 1'b1;
                take_irq = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter, fetch latch and execute stage.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pm_addr <= RESET_PC;
            fetch_q <= {IW{1'b0}};
            instr_word <= {IW{1'b0}};
            instr_valid <= 1'b0;
            irq_ack <= 1'b0;
        end
        else
        begin
            irq_ack <= take_irq;
            if (fetch_end)
                fetch_q <= pm_data;
            if (cycle_end)
            begin
                pm_addr <= next_pc;
                instr_word <= fetch_q;
                instr_valid <= ~next_discard;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data are taken in either order.
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_commit = aw_held & w_held & ~s_axi_bvalid;
    assign pcl_write = wr_commit & (aw_addr_q == `FES_ADDR_PCL) & w_strb_q[0];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr_q <= {`FES_AXI_AW{1'b0}};
            w_held <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FES_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_commit)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ((aw_addr_q == `FES_ADDR_PCL) || (aw_addr_q == `FES_ADDR_CTRL) ||
                    (aw_addr_q == `FES_ADDR_STAT))
                    s_axi_bresp <= `FES_RESP_OKAY;
                else
                    s_axi_bresp <= `FES_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers; a new low byte write wins over its own consumption.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_run <= `FES_CTRL_RESET;
            pcl_pend <= 1'b0;
            pcl_val <= {`FES_PCL_W{1'b0}};
        end
        else
        begin
            if (wr_commit && (aw_addr_q == `FES_ADDR_CTRL) && w_strb_q[0])
                ctrl_run <= w_data_q[`FES_CTRL_RUN_BIT];
            if (pcl_write)
            begin
                pcl_pend <= 1'b1;
                pcl_val <= w_data_q[`FES_PCL_W-1:0];
            end
            else if (take_pcl)
            begin
                pcl_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    assign s_axi_arready = ~s_axi_rvalid;

    always @*
    begin
        rd_mux = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `FES_ADDR_PCL: rd_mux[`FES_PCL_W-1:0] = pm_addr[`FES_PCL_W-1:0];
            `FES_ADDR_CTRL: rd_mux[`FES_CTRL_RUN_BIT] = ctrl_run;
            `FES_ADDR_STAT:
            begin
                rd_mux[`FES_STAT_PC_LSB +: PCW] = pm_addr;
                rd_mux[`FES_STAT_PHASE_LSB +: 4] = phase;
                rd_mux[`FES_STAT_LEVEL_LSB +: PW+1] = stack_level;
                rd_mux[`FES_STAT_FULL_BIT] = stack_full;
                rd_mux[`FES_STAT_PEND_BIT] = pcl_pend;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FES_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `FES_RESP_OKAY : `FES_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // fes_sequencer
`default_nettype wire

// ### rtl/fes_regs.vh
// Register offsets, field positions and reset values of the fetch and execute sequencer.
`ifndef FES_REGS_VH
`define FES_REGS_VH

// AXI4-Lite byte addresses of the registers.
`define FES_AXI_AW 4
`define FES_ADDR_PCL 4'h0
`define FES_ADDR_CTRL 4'h4
`define FES_ADDR_STAT 4'h8

// Control register fields and reset value.
`define FES_CTRL_RUN_BIT 0
`define FES_CTRL_RESET 1'b1

// Status register field positions.
`define FES_STAT_PC_LSB 0
`define FES_STAT_PHASE_LSB 12
`define FES_STAT_LEVEL_LSB 16
`define FES_STAT_FULL_BIT 19
`define FES_STAT_PEND_BIT 20

// Program counter and program word sizes.
`define FES_PC_W 11
`define FES_PCL_W 8
`define FES_INSTR_W 15
`define FES_RESET_VECTOR 11'h000

// Return address stack size.
`define FES_STACK_DEPTH 4
`define FES_STACK_PW 2

// Phases per instruction cycle.
`define FES_PHASES 4

// AXI responses.
`define FES_RESP_OKAY 2'h0
`define FES_RESP_SLVERR 2'h2

`endif

// ### rtl/fes_phase_gen.v
// Four-phase instruction cycle generator.
`timescale 1ns/10ps
`default_nettype none
module fes_phase_gen
(
    input wire aclk,
    input wire aresetn,
    input wire run,
    output reg [3:0] phase,
    output wire fetch_end,
    output wire cycle_end
);
    localparam [3:0] PH1 = 4'h1;
    localparam [3:0] PH2 = 4'h2;
    localparam [3:0] PH3 = 4'h4;
    localparam [3:0] PH4 = 4'h8;

    reg [3:0] next_phase;

    ////////////////////////////////////////////////////////////////////////////////
    // The phases rotate one per clock while run is high, so only one is ever active.
    always @*
    begin
        case (phase)
            PH1: next_phase = PH2;
            PH2: next_phase = PH3;
            PH3: next_phase = PH4;
            PH4: next_phase = PH1;
            default: next_phase = PH1;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            phase <= PH1;
        else if (run)
            phase <= next_phase;
    end

    assign fetch_end = run & (phase == PH1);
    assign cycle_end = run & (phase == PH4);
endmodule // fes_phase_gen
`default_nettype wire

// ### rtl/fes_ret_stack.v
// Return address stack for calls and interrupt acknowledges.
`timescale 1ns/10ps
`default_nettype none
module fes_ret_stack
#(
    parameter W = 11,
    parameter DEPTH = 4,
    parameter PW = 2
)
(
    input wire aclk,
    input wire aresetn,
    input wire push,
    input wire pop,
    input wire [W-1:0] push_data,
    output wire [W-1:0] top_data,
    output wire full,
    output reg [PW:0] level
);
    localparam [PW:0] FULL_LEVEL = DEPTH[PW:0];
    localparam [PW-1:0] PTR_ONE = 1;
    localparam [PW:0] LEVEL_ONE = 1;

    reg [W-1:0] mem [0:DEPTH-1];
    reg [PW-1:0] ptr;
    wire [PW-1:0] top_ptr;

    ////////////////////////////////////////////////////////////////////////////////
    // A push past a full stack overwrites the oldest entry.
    assign top_ptr = ptr - PTR_ONE;
    assign top_data = mem[top_ptr];
    assign full = (level == FULL_LEVEL);

    always @(posedge aclk)
    begin
        if (push)
            mem[ptr] <= push_data;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ptr <= {PW{1'b0}};
            level <= {(PW+1){1'b0}};
        end
        else if (push)
        begin
            ptr <= ptr + PTR_ONE;
            if (!full)
                level <= level + LEVEL_ONE;
        end
        else if (pop)
        begin
            ptr <= top_ptr;
            if (level != {(PW+1){1'b0}})
                level <= level - LEVEL_ONE;
        end
    end
endmodule // fes_ret_stack
`default_nettype wire

// ### tb/fes_prog_mem.sv
// Program memory model answering fetches with an address-derived word.
`timescale 1ns/10ps
`default_nettype none
module fes_prog_mem
(
    input wire logic aclk,
    input wire logic pm_rd,
    input wire logic [10:0] pm_addr,
    output logic [14:0] pm_data
);
    logic [14:0] last = 15'h0;
    always @(posedge aclk)
    begin
        last <= pm_data;
    end
    // Outside a fetch the bus toggles so a late sample cannot pass.
    assign pm_data = pm_rd ? {4'h5, pm_addr} : ~last;
endmodule // fes_prog_mem
`default_nettype wire

// ### tb/fes_seq_checker.sv
// Port checks of phase, fetch and counter behaviour.
`timescale 1ns/10ps
`default_nettype none
module fes_seq_checker
#(
    parameter PCW = 11
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PCW-1:0] pm_addr,
    input wire logic pm_rd,
    input wire logic [3:0] instruction_phase_clocks,
    input wire logic instr_valid,
    input wire logic ctl_jump,
    input wire logic ctl_call,
    input wire logic ctl_ret,
    input wire logic ctl_skip,
    input wire logic [PCW-1:0] ctl_target,
    input wire logic irq_req,
    input wire logic [PCW-1:0] irq_vector,
    input wire logic irq_ack
);
    wire logic [3:0] ph = instruction_phase_clocks;
    wire logic p4 = ph[3];
    wire logic go = p4 && instr_valid;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence dummy_s;
        !instr_valid [*4];
    endsequence
    phase_onehot_a: assert property ($onehot(ph)) else $error("phase");
    phase_turn_a: assert property ($changed(ph) |-> ph == {$past(ph[2:0]), $past(ph[3])})
        else $error("order");
    fetch_slot_a: assert property (pm_rd |-> ph[0]) else $error("fetch");
    pc_hold_a: assert property ($changed(pm_addr) |-> $past(p4)) else $error("hold");
    pc_step_a: assert property (go && !ctl_jump && !ctl_call && !ctl_ret && !ctl_skip
        && !irq_req |=> !instr_valid || pm_addr == $past(pm_addr) + 1'b1) else $error("step");
    branch_load_a: assert property (go && (ctl_jump || ctl_call)
        |=> pm_addr == $past(ctl_target) ##0 dummy_s) else $error("branch");
    skip_slot_a: assert property (go && ctl_skip && !ctl_jump && !ctl_call && !ctl_ret
        |=> pm_addr == $past(pm_addr) + 1'b1 ##0 dummy_s) else $error("skip");
    irq_entry_a: assert property ($rose(irq_ack) |-> $past(p4) && !instr_valid
        && pm_addr == $past(irq_vector)) else $error("irq");
    reset_start_a: assert property ($rose(aresetn) |-> pm_addr == 0 && ph == 4'h1)
        else $error("reset");
endmodule // fes_seq_checker
bind fes_sequencer fes_seq_checker #(.PCW(PCW)) chk
(
    .aclk(aclk), .aresetn(aresetn), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .instruction_phase_clocks(instruction_phase_clocks), .instr_valid(instr_valid),
    .ctl_jump(ctl_jump), .ctl_call(ctl_call), .ctl_ret(ctl_ret), .ctl_skip(ctl_skip),
    .ctl_target(ctl_target), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack)
);
`default_nettype wire

// ### tb/fes_sequencer_bench.sv
// Self-checking bench of the sequencer against a reference model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: mismatch", $time); end end
module fes_sequencer_bench;
    logic aclk = 1'h0, aresetn = 1'h0, aw = 1'h0, wv = 1'h0, br = 1'h0, ar = 1'h0, rr = 1'h0;
    logic c_jmp = 1'h0, c_call = 1'h0, c_ret = 1'h0, c_skip = 1'h0, irq = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, r = 32'h0, q = 32'h0;
    logic [10:0] tgt = 11'h0, vec = 11'h0, epc = 11'h0;
    wire awready, wready, bv, arready, rv, pm_rd, ivalid, ack;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [10:0] pm_addr;
    wire [14:0] pm_data, iword;
    wire [3:0] ph;
    int k = 0, i = 0, n_errors = 0, comparisons = 0, seed = 32'h0a8260bc;
    logic [14:0] ew = 15'h0;
    logic [7:0] program_counter_low_byte = 8'h0;
    logic [1:0] resp = 2'h0;
    logic ev = 1'h0, eack = 1'h0, pend = 1'h0, live = 1'h0, o = 1'h0;
    logic [10:0] stk[$];
    fes_prog_mem mem (.aclk(aclk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));
    fes_sequencer uut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(aw), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
        .instruction_phase_clocks(ph), .instr_word(iword), .instr_valid(ivalid),
        .ctl_jump(c_jmp), .ctl_call(c_call), .ctl_ret(c_ret), .ctl_skip(c_skip),
        .ctl_target(tgt), .irq_req(irq), .irq_vector(vec), .irq_ack(ack)
    );
    always #2 aclk = ~aclk;
    // Reference model, updated at each instruction cycle end.
    always @(posedge aclk)
    begin
        eack = 1'h0;
        live = aresetn;
        if (!aresetn)
        begin
            k = 0;
            epc = 11'h0;
            ev = 1'h0;
            pend = 1'h0;
            stk = {};
        end
        else if (++k % 4 == 0)
        begin
            ew = {4'h5, epc};
            o = ev;
            ev = 1'h0;
            if (o && (c_jmp || c_call))
            begin
                if (c_call)
                    stk.push_back(epc);
                epc = tgt;
            end
            else if (o && c_ret)
                epc = stk.pop_back();
            else if (o && c_skip)
                epc++;
            else if (pend)
            begin
                epc[7:0] = program_counter_low_byte;
                pend = 1'h0;
            end
            else if (irq && stk.size() < 4)
            begin
                stk.push_back(epc);
                epc = vec;
                eack = 1'h1;
            end
            else
            begin
                epc++;
                ev = 1'h1;
            end
            if (stk.size() > 4)
                stk.pop_front();
        end
    end
    always @(posedge aclk)
    begin
        r = $random(seed);
        c_jmp <= r[2:0] == 3'h0;
        c_call <= r[5:3] == 3'h0;
        c_ret <= r[7:6] == 2'h0 && stk.size() > 1;
        c_skip <= r[10:8] == 3'h0;
        irq <= r[13:11] == 3'h0;
        tgt <= r[26:16];
        vec <= r[31:21];
    end
    always @(negedge aclk)
    begin
        if (live)
        begin
            `CHK(pm_addr, epc)
            `CHK(ivalid, ev)
            `CHK(ack, eack)
            `CHK(pm_rd, k % 4 == 0)
            `CHK(ph, 4'h1 << k % 4)
            if (ev)
                `CHK(iword, ew)
        end
    end
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb, tq, tr;
        begin
            @(posedge aclk);
            awaddr <= a;
            araddr <= a;
            wdata <= d;
            {aw, wv, br} <= {3{wr}};
            {ar, rr} <= {2{!wr}};
            #1;
            while (aw || wv || br || ar || rr)
            begin
                @(negedge aclk);
                {ta, tw, tb} = {aw && awready, wv && wready, br && bv};
                {tq, tr} = {ar && arready, rr && rv};
                if (tb)
                    resp = bresp;
                if (tr)
                    {q, resp} = {rdata, rresp};
                @(posedge aclk);
                aw <= aw && !ta;
                wv <= wv && !tw;
                br <= br && !tb;
                ar <= ar && !tq;
                rr <= rr && !tr;
                #1;
            end
        end
    endtask
    task automatic align();
        do @(negedge aclk); while (k % 4 != 0);
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (800) @(posedge aclk);
        for (i = 0; i < 8; i++)
        begin
            align();
            program_counter_low_byte = 8'($random(seed));
            pend = 1'h1;
            xfer(1'h1, 4'h0, {24'h0, program_counter_low_byte});
            `CHK(resp, 2'h0)
            align();
            xfer(1'h0, 4'h0, 32'h0);
            `CHK(q, {24'h0, epc[7:0]})
        end
        xfer(1'h1, 4'h4, 32'h1);
        `CHK(resp, 2'h0)
        xfer(1'h0, 4'h4, 32'h0);
        `CHK(q[0], 1'h1)
        xfer(1'h1, 4'h8, 32'hffffffff);
        `CHK(resp, 2'h0)
        align();
        xfer(1'h0, 4'h8, 32'h0);
        `CHK(q, {11'h0, pend, stk.size() == 4, 3'(stk.size()), 4'h2, 1'h0, epc})
        xfer(1'h1, 4'hc, 32'h0);
        `CHK(resp, 2'h2)
        xfer(1'h0, 4'hc, 32'h0);
        `CHK({q, resp}, 34'h2)
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (800) @(posedge aclk);
        end_sim();
    end
endmodule // fes_sequencer_bench
`default_nettype wire
